// ---- us_pkg.sv ----
package us_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_FORMAT = 8'h0c;
  localparam logic [7:0] OFS_BAUD = 8'h10;
  // status bit positions
  localparam int ST_RXC = 7;
  localparam int ST_TXC = 6;
  localparam int ST_UDRE = 5;
  localparam int ST_FE = 4;
  localparam int ST_DOR = 3;
  localparam int ST_UPE = 2;
  // control bit positions
  localparam int CT_TX9 = 0;
  localparam int CT_RX9 = 1;
  localparam int CT_RXEN = 2;
  localparam int CT_TX_ENABLE_BIT = 3;
  localparam int CT_UDRIE = 4;
  localparam int CT_TXCIE = 5;
  // reset values, frame and oversampling constants, fifo depth
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [6:0] FORMAT_RST = 7'h03;
  localparam logic [11:0] BAUD_RST = 12'h000;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam int FIFO_DEPTH = 2;

  typedef struct packed {
    logic fe;
    logic dor;
    logic upe;
    logic [8:0] data;
  } us_rx_ent_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10
  } us_rx_state_t;
endpackage

// ---- us_data_path.sv ----
`timescale 1ns/100ps
module us_data_path (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // interrupt requests
  input wire logic i_global_irq_en,
  input wire logic i_txc_irq_ack,
  output logic o_irq_tx_empty,
  output logic o_irq_tx_done,
  // serial pins
  input wire logic i_serial_clock_pin,
  input wire logic i_rx_line_pin,
  output logic o_tx_line_pin,
  output logic o_tx_line_oe,
  output logic o_rx_pin_owned
);
  ////////////////////////////////////////////////////////////////////////
  logic ack_q, acc, wr, rd, wr_data, rd_data;
  logic [5:0] ctrl_q;
  logic [6:0] fmt_q;
  logic [11:0] baud_q;
  logic [11:0] div_q;
  logic tick, sck_q, sck_rise, sck_fall, sync_mode;
  logic [3:0] nbits;
  logic par_en, par_odd, two_stop;
  logic [8:0] txb_q;
  logic txb_valid_q, tx_busy_q, tx_act_q, txc_q, tx_bit, tx_load, tx_end;
  logic [12:0] tx_sh_q;
  logic [3:0] tx_cnt_q, tx_os_q, tx_len;
  us_pkg::us_rx_state_t rx_st_q;
  logic [3:0] rx_os_q, rx_idx_q;
  logic [9:0] rx_sh_q;
  logic rx_samp, rx_done, rx_push, rx_pop, dor_pend_q;
  us_pkg::us_rx_ent_t fifo_q [us_pkg::FIFO_DEPTH];
  us_pkg::us_rx_ent_t head, rx_ent;
  logic rd_ptr_q;
  logic [1:0] cnt_q;

  assign sync_mode = fmt_q[6];
  assign two_stop = fmt_q[5];
  assign par_en = fmt_q[4];
  assign par_odd = fmt_q[3];
  assign nbits = (fmt_q[2]) ? 4'h9 : {1'b0, fmt_q[2:0]} + 4'h5;

  ////////////////////////////////////////////////////////////////////////
  // bus slave: one wait state, unmapped reads return zero
  assign acc = i_wb_cyc && i_wb_stb && !ack_q;
  assign wr = acc && i_wb_we && i_wb_sel[0];
  assign rd = acc && !i_wb_we;
  assign wr_data = wr && (i_wb_adr == us_pkg::OFS_DATA);
  assign rd_data = rd && (i_wb_adr == us_pkg::OFS_DATA);
  assign o_wb_ack = ack_q;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc;
    end
  end

  assign head = fifo_q[rd_ptr_q];

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_wb_dat <= 32'h0000_0000;
    end else if (rd) begin
      o_wb_dat <= 32'h0000_0000;
      case (i_wb_adr)
        us_pkg::OFS_DATA: o_wb_dat[7:0] <= head.data[7:0];
        us_pkg::OFS_STATUS: begin
          o_wb_dat[us_pkg::ST_RXC] <= (cnt_q != 2'h0);
          o_wb_dat[us_pkg::ST_TXC] <= txc_q;
          o_wb_dat[us_pkg::ST_UDRE] <= !txb_valid_q;
          o_wb_dat[us_pkg::ST_FE] <= (cnt_q != 2'h0) && head.fe;
          o_wb_dat[us_pkg::ST_DOR] <= (cnt_q != 2'h0) && head.dor;
          o_wb_dat[us_pkg::ST_UPE] <= (cnt_q != 2'h0) && head.upe;
        end
        us_pkg::OFS_CTRL: begin
          o_wb_dat[5:0] <= ctrl_q;
          o_wb_dat[us_pkg::CT_RX9] <= head.data[8];
        end
        us_pkg::OFS_FORMAT: o_wb_dat[6:0] <= fmt_q;
        us_pkg::OFS_BAUD: o_wb_dat[11:0] <= baud_q;
        default: o_wb_dat <= 32'h0000_0000;
      endcase
    end
  end

  // software registers; the receive ninth bit is read-only
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctrl_q <= us_pkg::CTRL_RST;
      fmt_q <= us_pkg::FORMAT_RST;
      baud_q <= us_pkg::BAUD_RST;
    end else if (wr) begin
      case (i_wb_adr)
        us_pkg::OFS_CTRL: ctrl_q <= i_wb_dat[5:0] & 6'h3d;
        us_pkg::OFS_FORMAT: fmt_q <= i_wb_dat[6:0];
        us_pkg::OFS_BAUD: baud_q <= i_wb_dat[11:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // rate: async ticks at 16x the bit rate, sync uses pin edges
  assign tick = (div_q == baud_q);
  assign sck_rise = i_serial_clock_pin && !sck_q;
  assign sck_fall = !i_serial_clock_pin && sck_q;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      div_q <= 12'h000;
      sck_q <= 1'b0;
    end else begin
      div_q <= tick ? 12'h000 : div_q + 12'h001;
      sck_q <= i_serial_clock_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmitter
  function automatic logic [12:0] frame_f(logic [8:0] d, logic [3:0] nb,
                                          logic pe, logic po);
    logic [12:0] f;
    logic p;
    f = 13'h1fff;
    p = po;
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nb) begin
        f[i + 1] = d[i];
        p = p ^ d[i];
      end
    end
    if (pe) begin
      f[nb + 4'h1] = p;
    end
    return f;
  endfunction

  assign tx_len = nbits + {3'h0, par_en} + {3'h0, two_stop} + 4'h2;
  assign tx_bit = sync_mode ? sck_fall : (tick && tx_os_q == us_pkg::OS_LAST);
  assign tx_end = tx_busy_q && tx_bit && (tx_cnt_q == 4'h1);
  assign tx_load = tx_act_q && txb_valid_q && (!tx_busy_q || tx_end);

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 13'h1fff;
      tx_cnt_q <= 4'h0;
      tx_os_q <= 4'h0;
    end else begin
      tx_os_q <= (tx_load && !tx_busy_q) ? 4'h0 : tx_os_q + {3'h0, tick};
      if (tx_load) begin
        tx_sh_q <= frame_f(txb_q, nbits, par_en, par_odd);
        tx_cnt_q <= tx_len;
        tx_busy_q <= 1'b1;
      end else if (tx_end) begin
        tx_busy_q <= 1'b0;
      end else if (tx_busy_q && tx_bit) begin
        tx_sh_q <= {1'b1, tx_sh_q[12:1]};
        tx_cnt_q <= tx_cnt_q - 4'h1;
      end
    end
  end

  // single-entry buffer; a write while full overwrites it
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      txb_valid_q <= 1'b0;
      txb_q <= 9'h000;
    end else if (wr_data) begin
      txb_valid_q <= 1'b1;
      txb_q <= {ctrl_q[us_pkg::CT_TX9], i_wb_dat[7:0]};
    end else if (tx_load) begin
      txb_valid_q <= 1'b0;
    end
  end

  // disable is deferred until nothing is left to send
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      tx_act_q <= 1'b0;
    end else if (ctrl_q[us_pkg::CT_TX_ENABLE_BIT]) begin
      tx_act_q <= 1'b1;
    end else if (!txb_valid_q && !tx_busy_q) begin
      tx_act_q <= 1'b0;
    end
  end

  // set wins over both clears; status write of one clears
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      txc_q <= 1'b0;
    end else if (tx_end && !txb_valid_q) begin
      txc_q <= 1'b1;
    end else if (i_txc_irq_ack || (wr && i_wb_adr == us_pkg::OFS_STATUS
                                   && i_wb_dat[us_pkg::ST_TXC])) begin
      txc_q <= 1'b0;
    end
  end

  assign o_tx_line_pin = tx_busy_q ? tx_sh_q[0] : 1'b1;
  assign o_tx_line_oe = tx_act_q;
  assign o_irq_tx_empty = ctrl_q[us_pkg::CT_UDRIE] && i_global_irq_en
                          && !txb_valid_q;
  assign o_irq_tx_done = ctrl_q[us_pkg::CT_TXCIE] && i_global_irq_en
                         && txc_q;

  ////////////////////////////////////////////////////////////////////////
  // receiver
  assign o_rx_pin_owned = ctrl_q[us_pkg::CT_RXEN];
  assign rx_samp = (rx_st_q == us_pkg::RX_BITS) && (sync_mode ? sck_rise :
                   (tick && rx_os_q == us_pkg::OS_LAST));
  assign rx_done = rx_samp && (rx_idx_q == nbits + {3'h0, par_en});

  always_ff @(posedge i_core_clk) begin
    if (i_reset || !ctrl_q[us_pkg::CT_RXEN]) begin
      rx_st_q <= us_pkg::RX_IDLE;
      rx_os_q <= 4'h0;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 10'h000;
    end else begin
      case (rx_st_q)
        us_pkg::RX_IDLE: begin
          rx_os_q <= 4'h0;
          rx_idx_q <= 4'h0;
          if (sync_mode && sck_rise && !i_rx_line_pin) begin
            rx_st_q <= us_pkg::RX_BITS;
          end else if (!sync_mode && tick && !i_rx_line_pin) begin
            rx_st_q <= us_pkg::RX_START;
          end
        end
        us_pkg::RX_START: begin
          if (tick) begin
            rx_os_q <= rx_os_q + 4'h1;
            if (rx_os_q == us_pkg::OS_MID) begin
              rx_os_q <= 4'h0;
              rx_st_q <= i_rx_line_pin ? us_pkg::RX_IDLE : us_pkg::RX_BITS;
            end
          end
        end
        us_pkg::RX_BITS: begin
          rx_os_q <= rx_os_q + {3'h0, tick};
          if (rx_samp) begin
            rx_sh_q[rx_idx_q] <= i_rx_line_pin;
            rx_idx_q <= rx_idx_q + 4'h1;
          end
          if (rx_done) begin
            rx_st_q <= us_pkg::RX_IDLE;
          end
        end
        default: rx_st_q <= us_pkg::RX_IDLE;
      endcase
    end
  end

  // assemble the entry: mask high bits, check parity and first stop
  always_comb begin
    logic p;
    p = par_odd;
    rx_ent.data = 9'h000;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nbits) begin
        rx_ent.data[i] = rx_sh_q[i];
        p = p ^ rx_sh_q[i];
      end
    end
    rx_ent.upe = par_en && (rx_sh_q[nbits] != p);
    rx_ent.fe = !i_rx_line_pin;
    rx_ent.dor = dor_pend_q;
  end

  // a frame completing into a full fifo is lost and flagged
  assign rx_push = rx_done && (cnt_q != 2'h2);
  assign rx_pop = rd_data && (cnt_q != 2'h0);

  always_ff @(posedge i_core_clk) begin
    if (i_reset || !ctrl_q[us_pkg::CT_RXEN]) begin
      dor_pend_q <= 1'b0;
    end else if (rx_push) begin
      dor_pend_q <= 1'b0;
    end else if (rx_done) begin
      dor_pend_q <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset || !ctrl_q[us_pkg::CT_RXEN]) begin
      rd_ptr_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      rd_ptr_q <= rd_ptr_q ^ rx_pop;
      cnt_q <= cnt_q + {1'b0, rx_push} - {1'b0, rx_pop};
    end
  end

  for (genvar g = 0; g < us_pkg::FIFO_DEPTH; g++) begin : g_fifo
    always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
        fifo_q[g] <= '0;
      end else if (rx_push && (1'(g) == (rd_ptr_q ^ cnt_q[0]))) begin
        fifo_q[g] <= rx_ent;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  wr_clr_empty_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    wr_data |=> !o_irq_tx_empty && txb_valid_q)
    else $error("data write did not clear buffer-empty");
  load_sets_empty_a: assert property (@(posedge i_core_clk)
    disable iff (i_reset) tx_load && !wr_data |=> !txb_valid_q)
    else $error("buffer-empty not set after shifter load");
  empty_irq_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (ctrl_q[us_pkg::CT_UDRIE] && i_global_irq_en && !txb_valid_q)
    |-> o_irq_tx_empty)
    else $error("buffer-empty request missing");
  txc_set_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    tx_end && !txb_valid_q |=> txc_q)
    else $error("transmit complete not set");
  txc_ack_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_txc_irq_ack && !tx_end |=> !txc_q)
    else $error("transmit complete not cleared on service");
  txc_irq_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $rose(txc_q) && ctrl_q[us_pkg::CT_TXCIE] && i_global_irq_en
    |-> o_irq_tx_done)
    else $error("transmit complete request missing");
  tx_hold_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    tx_act_q && (txb_valid_q || tx_busy_q) |=> tx_act_q)
    else $error("transmitter released with data pending");
  rx_push_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    rx_push && !rx_pop && ctrl_q[us_pkg::CT_RXEN]
    |=> cnt_q == $past(cnt_q) + 2'h1)
    else $error("frame not moved to receive buffer");
  rx_pop_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    rx_pop && !rx_push && ctrl_q[us_pkg::CT_RXEN]
    |=> cnt_q == $past(cnt_q) - 2'h1 && rd_ptr_q != $past(rd_ptr_q))
    else $error("data read did not advance fifo");
  rx_flush_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    !ctrl_q[us_pkg::CT_RXEN] |=> cnt_q == 2'h0)
    else $error("receive buffer not flushed");
  tx_start_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    tx_load && !tx_busy_q |=> !o_tx_line_pin [*2])
    else $error("frame did not open with start bit");
  full_fifo_c: cover property (@(posedge i_core_clk) cnt_q == 2'h2);
  back_to_back_c: cover property (@(posedge i_core_clk) tx_end && tx_load);
  overrun_c: cover property (@(posedge i_core_clk) rx_done && !rx_push);
endmodule

// ---- us_peer.sv ----
`timescale 1ns/100ps
module us_peer (
  // clock
  input wire logic i_core_clk,
  // line pins
  input wire logic i_tx_line,
  output logic o_rx_line,
  // capture of frames sent by the block
  input wire logic [3:0] i_nbits,
  output logic [11:0] o_cap,
  output logic [7:0] o_cap_cnt,
  // serial clock for synchronous frames; idles low
  output logic o_sck
);
  initial begin
    o_sck = 1'b0;
    o_rx_line = 1'b1;
    o_cap = 12'h000;
    o_cap_cnt = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////
  // bit period is 16 core clocks at the reset baud setting
  task automatic send_bit(input logic b);
    o_rx_line <= b;
    repeat (16) @(posedge i_core_clk);
  endtask
  task automatic send_frame(input logic [8:0] d, input int n,
                            input logic par_en, input logic odd);
    logic p;
    p = odd;
    @(posedge i_core_clk);
    send_bit(1'b0);
    for (int i = 0; i < n; i++) begin
      send_bit(d[i]);
      p = p ^ d[i];
    end
    if (par_en) begin
      send_bit(p);
    end
    send_bit(1'b1);
    send_bit(1'b1);
  endtask
  // synchronous frame: line set while clock is low, sampled on its rise
  task automatic send_sync(input logic [8:0] d, input int n);
    @(posedge i_core_clk);
    for (int i = -1; i <= n; i++) begin
      o_rx_line <= (i < 0) ? 1'b0 : ((i == n) ? 1'b1 : d[i]);
      o_sck <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      o_sck <= 1'b1;
      repeat (4) @(posedge i_core_clk);
    end
    o_sck <= 1'b0;
    @(posedge i_core_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // sample mid-bit; i_nbits covers data, parity and first stop
  always begin
    @(posedge i_core_clk);
    if (i_tx_line === 1'b0) begin
      o_cap <= 12'h000;
      repeat (8) @(posedge i_core_clk);
      for (int i = 0; i < i_nbits; i++) begin
        repeat (16) @(posedge i_core_clk);
        o_cap[i] <= i_tx_line;
      end
      o_cap_cnt <= o_cap_cnt + 8'h01;
    end
  end
endmodule

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
  localparam logic [7:0] A_DAT = us_pkg::OFS_DATA;
  localparam logic [7:0] A_STS = us_pkg::OFS_STATUS;
  localparam logic [7:0] A_CTL = us_pkg::OFS_CTRL;
  localparam logic [7:0] A_FMT = us_pkg::OFS_FORMAT;
  logic clk, rst, cyc, stb, we, glob, txc_ack, ack, irq_e, irq_d;
  logic txp, txoe, rx_own, rx_line, tx_wire, sck;
  logic [7:0] adr, cap_cnt;
  logic [3:0] sel, nbits;
  logic [31:0] wdat, rdat, q;
  logic [11:0] cap;
  int fail_count = 0;
  int total_checks = 0;
  // a released transmit line is held high by its pull-up
  assign tx_wire = txoe ? txp : 1'b1;
  us_data_path dut (.i_core_clk(clk), .i_reset(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_global_irq_en(glob), .i_txc_irq_ack(txc_ack),
    .o_irq_tx_empty(irq_e), .o_irq_tx_done(irq_d),
    .i_serial_clock_pin(sck), .i_rx_line_pin(rx_line),
    .o_tx_line_pin(txp), .o_tx_line_oe(txoe), .o_rx_pin_owned(rx_own));
  us_peer peer (.i_core_clk(clk), .i_tx_line(tx_wire), .o_rx_line(rx_line),
    .i_nbits(nbits), .o_cap(cap), .o_cap_cnt(cap_cnt), .o_sck(sck));
  always #10 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic bail();
    fail_count++;
    $display("[ERR] %0t wait timed out", $time);
    wrap_up();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // ack is looked at mid-cycle, clear of the edge that launches it
    do begin
      @(negedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      bail();
    end
    // the next rising edge is the one at which ack is sampled high
    @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic poll(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      wb(1'b0, A_STS, 32'h0);
      n++;
    end while ((q & m) == 32'h0 && n < 100);
    if ((q & m) == 32'h0) begin
      bail();
    end
  endtask
  task automatic wait_cap(input logic [7:0] c);
    int n;
    n = 0;
    while (cap_cnt !== c && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (cap_cnt !== c) begin
      bail();
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic test_reset_irq();
    wb(1'b0, A_STS, 32'h0);
    chk(q, 32'h20);
    wb(1'b1, 8'h40, 32'hff);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    chk(irq_e, 1'b0);
    wb(1'b1, A_CTL, 32'h10);
    chk(irq_e, 1'b1);
    glob <= 1'b0;
    @(posedge clk);
    chk(irq_e, 1'b0);
    glob <= 1'b1;
  endtask
  task automatic test_tx_parity();
    nbits = 4'd10;
    wb(1'b1, A_FMT, 32'h13);
    wb(1'b1, A_DAT, 32'ha5);
    wb(1'b0, A_STS, 32'h0);
    chk(q, 32'h00);
    wb(1'b1, A_CTL, 32'h28);
    wait_cap(8'h01);
    chk(cap, 12'h2a5);
    poll(32'h40);
    chk(q, 32'h60);
    chk(irq_d, 1'b1);
    @(posedge clk);
    txc_ack <= 1'b1;
    @(posedge clk);
    txc_ack <= 1'b0;
    wb(1'b0, A_STS, 32'h0);
    chk(q, 32'h20);
  endtask
  task automatic test_tx_defer();
    nbits = 4'd9;
    wb(1'b1, A_FMT, 32'h1a);
    wb(1'b1, A_DAT, 32'h3c);
    wb(1'b1, A_DAT, 32'h55);
    wb(1'b0, A_STS, 32'h0);
    chk(q, 32'h00);
    wb(1'b1, A_CTL, 32'h00);
    chk(txoe, 1'b1);
    wait_cap(8'h02);
    chk(cap, 12'h1bc);
    wait_cap(8'h03);
    chk(cap, 12'h1d5);
    poll(32'h40);
    chk(q, 32'h60);
    chk(txoe, 1'b0);
    wb(1'b1, A_STS, 32'h40);
    wb(1'b0, A_STS, 32'h0);
    chk(q, 32'h20);
  endtask
  task automatic test_rx();
    wb(1'b1, A_CTL, 32'h04);
    chk(rx_own, 1'b1);
    wb(1'b1, A_FMT, 32'h07);
    peer.send_frame(9'h1a5, 9, 1'b0, 1'b0);
    peer.send_frame(9'h05a, 9, 1'b0, 1'b0);
    wb(1'b0, A_CTL, 32'h0);
    chk(q, 32'h06);
    wb(1'b0, A_STS, 32'h0);
    chk(q, 32'ha0);
    wb(1'b0, A_DAT, 32'h0);
    chk(q, 32'ha5);
    wb(1'b0, A_CTL, 32'h0);
    chk(q, 32'h04);
    wb(1'b0, A_DAT, 32'h0);
    chk(q, 32'h5a);
    wb(1'b0, A_STS, 32'h0);
    chk(q, 32'h20);
    wb(1'b1, A_FMT, 32'h00);
    peer.send_frame(9'h1ff, 5, 1'b0, 1'b0);
    wb(1'b0, A_DAT, 32'h0);
    chk(q, 32'h1f);
    peer.send_frame(9'h00a, 5, 1'b0, 1'b0);
    wb(1'b1, A_CTL, 32'h00);
    wb(1'b0, A_STS, 32'h0);
    chk(q, 32'h20);
    chk(rx_own, 1'b0);
  endtask
  task automatic test_rx_sync();
    wb(1'b1, A_FMT, 32'h43);
    wb(1'b1, A_CTL, 32'h04);
    peer.send_sync(9'h0c3, 8);
    wb(1'b0, A_STS, 32'h0);
    chk(q, 32'ha0);
    wb(1'b0, A_DAT, 32'h0);
    chk(q, 32'hc3);
    wb(1'b1, A_CTL, 32'h00);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, we, txc_ack} = 4'h0;
    glob = 1'b1;
    adr = 8'h00;
    sel = 4'h1;
    wdat = 32'h0;
    nbits = 4'd10;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    test_reset_irq();
    test_tx_parity();
    test_tx_defer();
    test_rx();
    test_rx_sync();
    wrap_up();
  end
endmodule
